// [inc/pdc_defs.svh]
// offsets, field positions, reset values and sync depth for the device cap/control bank
`ifndef PDC_DEFS_SVH
`define PDC_DEFS_SVH
// register byte offsets
`define PDC_OFS_CAP       12'h0c4
`define PDC_OFS_CTL       12'h0c8
// capabilities fields
`define PDC_CAP_MPS_HI    2
`define PDC_CAP_MPS_LO    0
`define PDC_CAP_RBER      15
`define PDC_CAP_SPLV_HI   25
`define PDC_CAP_SPLV_LO   18
`define PDC_CAP_SPLS_HI   27
`define PDC_CAP_SPLS_LO   26
// control fields
`define PDC_CTL_ERR_HI    3
`define PDC_CTL_ERR_LO    0
`define PDC_CTL_MPS_HI    7
`define PDC_CTL_MPS_LO    5
`define PDC_CTL_AUX       10
// reset values
`define PDC_MPS_256       3'h1
`define PDC_MPS_512       3'h2
`define PDC_RBER_RST      1'h1
`define PDC_SPLV_RST      8'h00
`define PDC_SPLS_RST      2'h0
`define PDC_ERR_RST       4'h0
`define PDC_MPSP_RST      3'h0
`define PDC_AUX_RST       1'h0
`define PDC_DATA_ZERO     32'h0000_0000
// pin synchroniser depth
`define PDC_SYNC_DEPTH    3
`endif

// [inc/pdc_pkg.sv]
// types shared by the device cap/control bank
package pdc_pkg;
	typedef logic [2:0]  pdc_size_t;   // payload size code
	typedef logic [7:0]  pdc_splv_t;   // slot power value
	typedef logic [1:0]  pdc_spls_t;   // slot power scale
	typedef logic [31:0] pdc_word_t;   // bus word
endpackage : pdc_pkg

// [core/pdc_regs.sv]
// device capabilities and device control registers behind an apb slave
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "pdc_defs.svh"

module pdc_regs (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                sticky_rstn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                payload_512_strap,
	input  wire logic                upstream_strap,
	input  wire logic                load_valid,
	input  wire logic [2:0]          load_mps,
	input  wire logic                load_rber,
	input  wire logic                spl_valid,
	input  wire logic [7:0]          spl_value,
	input  wire logic [1:0]          spl_scale,
	output logic      [2:0]          mps_supported,
	output logic      [3:0]          err_report_en,
	output logic      [2:0]          max_payload,
	output logic                     aux_pm_en,
	output logic      [7:0]          slot_power_value,
	output logic      [1:0]          slot_power_scale
);

	// ****************************************
	// strap synchronisers
	// ****************************************
	logic [1:0]               sync1_reg;    // first stage, read by stage two only
	logic [1:0]               sync2_reg;    // second stage
	logic [1:0]               sync3_reg;    // third stage
	logic [1:0]               strap_reg;    // filtered straps: bit0 payload, bit1 upstream
	logic [1:0]               strap_next;   // next filtered straps
	logic [1:0]               strap_diff;   // stages two and three disagree

	// a strap change counts only once stages two and three agree
	always_comb begin
		strap_diff = sync2_reg ^ sync3_reg;
		strap_next = (sync2_reg & ~strap_diff) | (strap_reg & strap_diff);
	end

	// shift the pins in, then update the filtered copy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= 2'h0;
			sync2_reg <= 2'h0;
			sync3_reg <= 2'h0;
			strap_reg <= 2'h0;
		end else begin
			sync1_reg <= {upstream_strap, payload_512_strap};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			strap_reg <= strap_next;
		end
	end

	// ****************************************
	// capabilities state
	// ****************************************
	pdc_pkg::pdc_size_t       sup_reg;      // supported payload size
	pdc_pkg::pdc_size_t       sup_next;
	logic                     ovr_reg;      // a loader has replaced the strap default
	logic                     ovr_next;
	logic                     rber_reg;     // role-based error reporting
	logic                     rber_next;
	pdc_pkg::pdc_splv_t       splv_reg;     // captured slot power value
	pdc_pkg::pdc_splv_t       splv_next;
	pdc_pkg::pdc_spls_t       spls_reg;     // captured slot power scale
	pdc_pkg::pdc_spls_t       spls_next;

	// strap sets the default until smbus or eeprom load overrides it
	always_comb begin
		ovr_next  = ovr_reg;
		rber_next = rber_reg;
		sup_next  = strap_reg[0] ? `PDC_MPS_512 : `PDC_MPS_256;
		splv_next = splv_reg;
		spls_next = spls_reg;
		if (load_valid) begin
			// loader value wins and sticks
			ovr_next  = 1'b1;
			rber_next = load_rber;
		end
		if (load_valid) begin
			sup_next = load_mps;
		end else if (ovr_reg) begin
			sup_next = sup_reg;
		end
		// only the upstream port captures the message
		if (spl_valid && strap_reg[1]) begin
			splv_next = spl_value;
			spls_next = spl_scale;
		end
	end

	// capabilities registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sup_reg  <= `PDC_MPS_256;
			ovr_reg  <= 1'b0;
			rber_reg <= `PDC_RBER_RST;
			splv_reg <= `PDC_SPLV_RST;
			spls_reg <= `PDC_SPLS_RST;
		end else begin
			sup_reg  <= sup_next;
			ovr_reg  <= ovr_next;
			rber_reg <= rber_next;
			splv_reg <= splv_next;
			spls_reg <= spls_next;
		end
	end

	// ****************************************
	// apb decode
	// ****************************************
	logic                     hit_cap;      // address selects capabilities
	logic                     hit_ctl;      // address selects control
	logic                     wr_done;      // write completes this edge
	pdc_pkg::pdc_word_t       cap_word;     // capabilities read image
	pdc_pkg::pdc_word_t       ctl_word;     // control read image

	// ****************************************
	// control state
	// ****************************************
	logic [3:0]               err_reg;      // error reporting enables
	logic [3:0]               err_next;
	pdc_pkg::pdc_size_t       mpsp_reg;     // programmed payload size
	pdc_pkg::pdc_size_t       mpsp_next;
	logic                     aux_reg;      // sticky aux power enable
	logic                     aux_next;
	pdc_pkg::pdc_size_t       wr_mps;       // written payload field

	// write only at the access edge that sees pready
	always_comb begin
		hit_cap = (paddr == `PDC_OFS_CAP);
		hit_ctl = (paddr == `PDC_OFS_CTL);
		wr_done = psel && penable && pwrite && pready && hit_ctl;
		wr_mps  = pwdata[`PDC_CTL_MPS_HI:`PDC_CTL_MPS_LO];
		err_next  = err_reg;
		mpsp_next = mpsp_reg;
		aux_next  = aux_reg;
		if (wr_done && pstrb[0]) begin
			err_next = pwdata[`PDC_CTL_ERR_HI:`PDC_CTL_ERR_LO];
			// too large a value is stored as the supported one
			mpsp_next = (wr_mps > sup_reg) ? sup_reg : wr_mps;
		end
		if (wr_done && pstrb[1]) begin
			aux_next = pwdata[`PDC_CTL_AUX];
		end
	end

	// hot-resettable control fields
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_reg  <= `PDC_ERR_RST;
			mpsp_reg <= `PDC_MPSP_RST;
		end else begin
			err_reg  <= err_next;
			mpsp_reg <= mpsp_next;
		end
	end

	// sticky field survives the port reset, only the sticky reset clears it
	always_ff @(posedge pclk or negedge sticky_rstn) begin
		if (!sticky_rstn) begin
			aux_reg <= `PDC_AUX_RST;
		end else begin
			aux_reg <= aux_next;
		end
	end

	// ****************************************
	// read images
	// ****************************************
	// hardwired and reserved fields stay zero
	always_comb begin
		cap_word = `PDC_DATA_ZERO;
		cap_word[`PDC_CAP_MPS_HI:`PDC_CAP_MPS_LO]   = sup_reg;
		cap_word[`PDC_CAP_RBER]                     = rber_reg;
		cap_word[`PDC_CAP_SPLV_HI:`PDC_CAP_SPLV_LO] = splv_reg;
		cap_word[`PDC_CAP_SPLS_HI:`PDC_CAP_SPLS_LO] = spls_reg;
		ctl_word = `PDC_DATA_ZERO;
		ctl_word[`PDC_CTL_ERR_HI:`PDC_CTL_ERR_LO]   = err_reg;
		ctl_word[`PDC_CTL_MPS_HI:`PDC_CTL_MPS_LO]   = mpsp_reg;
		ctl_word[`PDC_CTL_AUX]                      = aux_reg;
	end

	// ****************************************
	// apb answer
	// ****************************************
	logic [31:0]              prdata_next;
	logic                     pready_next;
	logic                     pslverr_next;

	// answer is prepared in the setup cycle, ready in the first access cycle
	always_comb begin
		prdata_next  = prdata;
		pready_next  = 1'b0;
		pslverr_next = 1'b0;
		if (psel && !penable) begin
			pready_next  = 1'b1;
			// unmapped offsets read zero and flag an error
			pslverr_next = !(hit_cap || hit_ctl);
			if (pwrite) begin
				prdata_next = `PDC_DATA_ZERO;
			end else if (hit_cap) begin
				prdata_next = cap_word;
			end else if (hit_ctl) begin
				prdata_next = ctl_word;
			end else begin
				prdata_next = `PDC_DATA_ZERO;
			end
		end
	end

	// bus answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= `PDC_DATA_ZERO;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= prdata_next;
			pready  <= pready_next;
			pslverr <= pslverr_next;
		end
	end

	// ****************************************
	// user outputs
	// ****************************************
	// each user output is a plain copy of its register
	always_comb begin
		mps_supported    = sup_reg;
		err_report_en    = err_reg;
		max_payload      = mpsp_reg;
		aux_pm_en        = aux_reg;
		slot_power_value = splv_reg;
		slot_power_scale = spls_reg;
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic rd_cap;   // read of capabilities completes
	logic rd_ctl;   // read of control completes
	always_comb begin
		rd_cap = psel && penable && !pwrite && pready && hit_cap;
		rd_ctl = psel && penable && !pwrite && pready && hit_ctl;
	end

	a_strap_default: assert property (!ovr_reg && !load_valid |=>
		sup_reg == ($past(strap_reg[0]) ? 3'h2 : 3'h1))
		else $error("supported payload does not follow strap");
	a_load_replace: assert property (load_valid |=> ovr_reg && sup_reg == $past(load_mps) ##1
		(load_valid || sup_reg == $past(sup_reg)))
		else $error("loaded payload size not kept");
	a_cap_phantom: assert property (rd_cap |-> prdata[4:3] == 2'h0)
		else $error("phantom supported not zero");
	a_cap_exttag: assert property (rd_cap |-> !prdata[5])
		else $error("extended tag supported not zero");
	a_cap_latency: assert property (rd_cap |-> prdata[11:6] == 6'h00)
		else $error("acceptable latency not zero");
	a_rber_load: assert property (load_valid |=> rber_reg == $past(load_rber))
		else $error("role-based error bit not loaded");
	a_splv_capture: assert property (spl_valid && strap_reg[1] |=> splv_reg == $past(spl_value))
		else $error("slot power value not captured");
	a_spls_capture: assert property (spl_valid && strap_reg[1] |=> spls_reg == $past(spl_scale))
		else $error("slot power scale not captured");
	a_spl_downstream: assert property (!strap_reg[1] |=> $stable(splv_reg) && $stable(spls_reg))
		else $error("downstream port changed slot power");
	a_err_write: assert property (wr_done && pstrb[0] |=> err_report_en == $past(pwdata[3:0]))
		else $error("error enables not written");
	a_ctl_zeros: assert property (rd_ctl |-> prdata[4] == 1'b0 && prdata[9:8] == 2'h0
		&& prdata[31:11] == 21'h00_0000)
		else $error("hardwired control bits not zero");
	a_mps_clamp: assert property (wr_done && pstrb[0] |=> max_payload ==
		(($past(pwdata[7:5]) > $past(sup_reg)) ? $past(sup_reg) : $past(pwdata[7:5])))
		else $error("programmed payload not clamped");
	a_aux_write: assert property (wr_done && pstrb[1] |=> aux_pm_en == $past(pwdata[10]))
		else $error("aux power enable not written");
	a_rsvd_zero: assert property (rd_cap |-> prdata[17:16] == 2'h0 && prdata[14:12] == 3'h0
		&& prdata[31:28] == 4'h0)
		else $error("reserved capability bits not zero");
	a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not a single access cycle");
	// a read of either register shows the state of the setup cycle
	a_cap_read: assert property (rd_cap |-> prdata[2:0] == $past(sup_reg)
		&& prdata[15] == $past(rber_reg) && prdata[27:18] == {$past(spls_reg), $past(splv_reg)})
		else $error("capabilities read image wrong");
	a_ctl_read: assert property (rd_ctl |-> prdata[3:0] == $past(err_reg)
		&& prdata[7:5] == $past(mpsp_reg) && prdata[10] == $past(aux_reg))
		else $error("control read image wrong");
	// bytes with their strobe low keep their old contents
	a_strb_keep: assert property (wr_done && !pstrb[0] |=> $stable(err_report_en) && $stable(max_payload))
		else $error("unstrobed low byte written");
	a_aux_keep: assert property (wr_done && !pstrb[1] |=> $stable(aux_pm_en))
		else $error("unstrobed aux enable written");
	// role-based error bit moves only with a loader pulse
	a_rber_hold: assert property (!load_valid |=> $stable(rber_reg))
		else $error("role-based error bit changed without load");
	// mapped offsets never flag an error
	a_slverr_mapped: assert property (psel && !penable && (hit_cap || hit_ctl) |=> pready && !pslverr)
		else $error("error flagged on mapped offset");
	a_unmapped_err: assert property (psel && !penable && !(hit_cap || hit_ctl) |=>
		pslverr && prdata == 32'h0000_0000)
		else $error("unmapped offset not refused");

	// main scenarios seen at least once
	c_clamped_write: cover property (wr_done && pwdata[7:5] > sup_reg);
	c_loader_run: cover property (load_valid ##[1:20] rd_cap);
	c_slot_power: cover property (spl_valid && strap_reg[1] ##[1:10] rd_cap);
	c_unmapped: cover property (psel && penable && pready && pslverr);
	c_upstream_set: cover property ($rose(strap_reg[1]));

endmodule : pdc_regs

// [sim/pdc_tb.sv]
// self-checking bench for the device capabilities and control register bank
`timescale 1ns/1ps
module tb;
	// ************
	// signals
	// ************
	logic        pclk, presetn, sticky_rstn;            // clock and resets
	logic        psel, penable, pwrite;                 // apb controls
	logic [11:0] paddr;                                 // apb address
	logic [31:0] pwdata, prdata, rdat;                  // apb data, last read
	logic [3:0]  pstrb, err_report_en;                  // strobes, error enables
	logic        pready, pslverr, rerr;                 // apb answer, captured
	logic        payload_512_strap, upstream_strap;     // strap pins
	logic        load_valid, load_rber, spl_valid;      // loader and message pulses
	logic [2:0]  load_mps, mps_supported, max_payload;  // payload codes
	logic [7:0]  spl_value, slot_power_value;           // slot power value
	logic [1:0]  spl_scale, slot_power_scale;           // slot power scale
	logic        aux_pm_en;                             // sticky aux enable
	int          errors, check_count;                   // tallies

	pdc_regs dut (.pclk, .presetn, .sticky_rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .payload_512_strap, .upstream_strap, .load_valid, .load_mps,
		.load_rber, .spl_valid, .spl_value, .spl_scale, .mps_supported, .err_report_en,
		.max_payload, .aux_pm_en, .slot_power_value, .slot_power_scale);

	// 50 ns clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// ************
	// shared tasks
	// ************
	// verdict and end of run
	task automatic report_and_stop;
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	// word compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer, answer taken at the rising edge that sees pready high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		pstrb  <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
			if (n > 16) begin
				errors++;
				report_and_stop();
			end
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// read and compare data and error
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0000_0000, 4'h0);
		chk(rdat, e);
		chk(32'(rerr), 32'(ee));
	endtask : rd

	// write and compare error
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic ee);
		apb(1'b1, a, d, s);
		chk(32'(rerr), 32'(ee));
	endtask : wr

	// bounded wait for supported payload code
	task automatic wait_mps(input logic [2:0] e);
		int n;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
			if (n > 12) begin
				errors++;
				report_and_stop();
			end
		end while (mps_supported !== e);
		@(posedge pclk);
	endtask : wait_mps

	// slot power message pulse
	task automatic spl(input logic [7:0] v, input logic [1:0] s);
		spl_value <= v;
		spl_scale <= s;
		spl_valid <= 1'b1;
		@(posedge pclk);
		spl_valid <= 1'b0;
		@(posedge pclk);
	endtask : spl

	// ************
	// scenarios
	// ************
	task automatic t_reset_vals;
		wait_mps(3'h1);
		rd(12'h0c4, 32'h0000_8001, 1'b0);
		rd(12'h0c8, 32'h0000_0000, 1'b0);
	endtask : t_reset_vals

	task automatic t_strap_high;
		payload_512_strap <= 1'b1;
		wait_mps(3'h2);
		rd(12'h0c4, 32'h0000_8002, 1'b0);
	endtask : t_strap_high

	task automatic t_ctl;
		wr(12'h0c8, 32'hffff_ffff, 4'hf, 1'b0);
		rd(12'h0c8, 32'h0000_044f, 1'b0);
		chk(32'({err_report_en, max_payload, aux_pm_en}), 32'h0000_00f5);
		wr(12'h0c8, 32'h0000_0020, 4'h1, 1'b0);
		wr(12'h0c8, 32'h0000_000f, 4'h0, 1'b0);
		rd(12'h0c8, 32'h0000_0420, 1'b0);
		wr(12'h0c4, 32'hffff_ffff, 4'hf, 1'b0);
		rd(12'h0c4, 32'h0000_8002, 1'b0);
	endtask : t_ctl

	task automatic t_unmapped;
		wr(12'h0d0, 32'hffff_ffff, 4'hf, 1'b1);
		rd(12'h0d0, 32'h0000_0000, 1'b1);
	endtask : t_unmapped

	task automatic t_slot;
		spl(8'ha5, 2'h2);
		rd(12'h0c4, 32'h0000_8002, 1'b0);
		upstream_strap <= 1'b1;
		repeat (6) @(posedge pclk);
		spl(8'ha5, 2'h2);
		chk(32'({slot_power_value, slot_power_scale}), 32'h0000_0296);
		rd(12'h0c4, 32'h0a94_8002, 1'b0);
	endtask : t_slot

	task automatic t_loader;
		load_mps   <= 3'h5;
		load_rber  <= 1'b0;
		load_valid <= 1'b1;
		@(posedge pclk);
		load_valid <= 1'b0;
		@(posedge pclk);
		rd(12'h0c4, 32'h0a94_0005, 1'b0);
		wr(12'h0c8, 32'h0000_00e0, 4'h1, 1'b0);
		rd(12'h0c8, 32'h0000_04a0, 1'b0);
	endtask : t_loader

	task automatic t_sticky;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(12'h0c8, 32'h0000_0400, 1'b0);
		wait_mps(3'h2);
		rd(12'h0c4, 32'h0000_8002, 1'b0);
	endtask : t_sticky

	// ************
	// main sequence
	// ************
	initial begin
		errors = 0;
		check_count = 0;
		{presetn, sticky_rstn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{payload_512_strap, upstream_strap, load_valid, load_mps, load_rber} = '0;
		{spl_valid, spl_value, spl_scale} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		sticky_rstn <= 1'b1;
		t_reset_vals();
		t_strap_high();
		t_ctl();
		t_unmapped();
		t_slot();
		t_loader();
		t_sticky();
		report_and_stop();
	end
endmodule : tb
